// ---- sepc_top.sv ----
/*
 sepc_top: serial eeprom command decoder, self-timed programming engine
 and ready/busy output. assumes asynchronous pins from a host that obeys
 select low time and clock counts; one 40 MHz clock.
*/
`timescale 1ns/1ps
module sepc_top
    import sepc_pkg::*;
#(
    parameter int unsigned WORD_CYCLES = WORD_CYC,
    parameter int unsigned BULK_ERASE_CYCLES = BULK_ERASE_CYC,
    parameter int unsigned BULK_WRITE_CYCLES = BULK_WRITE_CYC
)(
    input logic clk,
    input logic resetn,
    input logic chip_select,
    input logic serial_clk,
    input logic serial_in,
    input logic word_width_select,
    output logic serial_out,
    output logic serial_out_oe
);
    // =====================================================================
    // reset release and pin synchronisers
    logic [1:0] rst_q;
    logic rst_n;
    logic [3:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
    logic cs_n, cs_lvl, cs_fall, cs_rise, sclk_rise, sdi_n, org_n;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rst_q <= 2'h0;
        else
            rst_q <= {rst_q[0], 1'h1};
    end
    assign rst_n = rst_q[1];

    // a change counts only when the second and third stage agree
    assign filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_r <= 4'h0;
            s2_r <= 4'h0;
            s3_r <= 4'h0;
            filt_r <= 4'h0;
        end
        else
        begin
            s1_r <= {chip_select, serial_clk, serial_in, word_width_select};
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= filt_nxt;
        end
    end

    assign cs_n = filt_nxt[3];
    assign cs_lvl = filt_r[3];
    assign cs_fall = cs_lvl && !cs_n;
    assign cs_rise = !cs_lvl && cs_n;
    assign sclk_rise = filt_nxt[2] && !filt_r[2];
    assign sdi_n = filt_nxt[1];
    assign org_n = filt_nxt[0];

    // =====================================================================
    // command buffer and array
    sepc_cmd_s cmd_r, cmd_nxt, pend_cmd;
    sepc_mem_req_s mreq;
    logic push, buf_in_ready, buf_out_valid, buf_out_ready;
    logic [$bits(sepc_cmd_s)-1:0] pend_bits;
    logic [AW:0] rd_addr_r, rd_addr_nxt;
    logic [15:0] rdata;
    logic busy_r, ready;

    sepc_buf2 #(.W($bits(sepc_cmd_s))) u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(push),
        .in_ready(buf_in_ready),
        .in_data(cmd_r),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(pend_bits)
    );
    assign pend_cmd = sepc_cmd_s'(pend_bits);

    sepc_mem #(.ADDR_W(AW)) u_mem (
        .clk(clk),
        .we(mreq.we),
        .be(mreq.be),
        .waddr(mreq.addr),
        .wdata(mreq.wdata),
        .raddr(rd_addr_r[AW:1]),
        .rdata(rdata)
    );

    assign ready = !busy_r && !buf_out_valid;

    // =====================================================================
    // serial command decoder
    sepc_ser_e ser_r, ser_nxt;
    logic [4:0] cnt_r, cnt_nxt, ocnt_r, ocnt_nxt;
    logic [4:0] addr_bits, hdr_bits, end_bits;
    logic [24:0] sh_r, sh_nxt, sh_in;
    logic wide_r, wide_nxt, done_r, done_nxt, stat_r, stat_nxt;
    logic oe_r, oe_nxt, dout_r, dout_nxt;
    logic [15:0] osh_r, osh_nxt;
    logic [1:0] rwait_r, rwait_nxt, opc, sub;
    logic [7:0] low_r, low_nxt;
    logic [AW:0] baddr;

    assign addr_bits = wide_r ? 5'(AW) : 5'(AW + 1);
    assign hdr_bits = addr_bits + 5'h2;
    assign end_bits = hdr_bits + (wide_r ? 5'h10 : 5'h08);
    assign sh_in = {sh_r[23:0], sdi_n};
    assign opc = 2'(sh_in >> addr_bits);
    assign sub = wide_r ? sh_in[AW-1 -: 2] : sh_in[AW -: 2];
    assign baddr = wide_r ? {sh_in[AW-1:0], 1'h0} : sh_in[AW:0];
    assign push = cs_fall && done_r;

    always_comb
    begin
        ser_nxt = ser_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        wide_nxt = wide_r;
        cmd_nxt = cmd_r;
        done_nxt = done_r;
        rd_addr_nxt = rd_addr_r;
        rwait_nxt = rwait_r;
        osh_nxt = osh_r;
        ocnt_nxt = ocnt_r;
        dout_nxt = dout_r;
        stat_nxt = stat_r;
        low_nxt = low_r;
        if (!cs_n)
        begin
            // deselect returns the decoder to idle and clears its count, done, status and read-wait state
            ser_nxt = SP_IDLE;
            cnt_nxt = 5'h0;
            done_nxt = 1'h0;
            stat_nxt = 1'h0;
            rwait_nxt = 2'h0;
            if (low_r != 8'(SELECT_LOW_CYC))
                low_nxt = low_r + 8'h1;
        end
        else
        begin
            low_nxt = 8'h0;
            // status only after a full select low time
            if (cs_rise && low_r == 8'(SELECT_LOW_CYC) && (busy_r || buf_out_valid))
                stat_nxt = 1'h1;
            if (sclk_rise)
            begin
                unique case (ser_r)
                    SP_IDLE:
                    begin
                        // a start is refused while the buffer is full
                        if (sdi_n && buf_in_ready)
                        begin
                            ser_nxt = SP_SHIFT;
                            cnt_nxt = 5'h0;
                            wide_nxt = org_n;
                            stat_nxt = 1'h0;
                        end
                    end
                    SP_SHIFT:
                    begin
                        sh_nxt = sh_in;
                        cnt_nxt = cnt_r + 5'h1;
                        if (cnt_r + 5'h1 == hdr_bits)
                        begin
                            cmd_nxt.wide = wide_r;
                            cmd_nxt.baddr = baddr;
                            cmd_nxt.data = 16'h0000;
                            ser_nxt = SP_DONE;
                            done_nxt = 1'h1;
                            unique case (opc)
                                OPC_READ:
                                begin
                                    ser_nxt = SP_READ;
                                    done_nxt = 1'h0;
                                    rd_addr_nxt = baddr;
                                    rwait_nxt = 2'h2;
                                    ocnt_nxt = 5'h0;
                                    dout_nxt = 1'h0;
                                end
                                OPC_ERASE: cmd_nxt.op = CMD_ERASE;
                                OPC_WRITE:
                                begin
                                    cmd_nxt.op = CMD_WRITE;
                                    ser_nxt = SP_SHIFT;
                                    done_nxt = 1'h0;
                                end
                                OPC_SPECIAL:
                                begin
                                    unique case (sub)
                                        SUB_UNLOCK: cmd_nxt.op = CMD_UNLOCK;
                                        SUB_LOCK: cmd_nxt.op = CMD_LOCK;
                                        SUB_BULK_ERASE: cmd_nxt.op = CMD_BULK_ERASE;
                                        SUB_BULK_WRITE:
                                        begin
                                            cmd_nxt.op = CMD_BULK_WRITE;
                                            ser_nxt = SP_SHIFT;
                                            done_nxt = 1'h0;
                                        end
                                    endcase
                                end
                            endcase
                        end
                        else if (cnt_r + 5'h1 == end_bits)
                        begin
                            // narrow data is mirrored into both lanes
                            cmd_nxt.data = wide_r ? sh_in[15:0] : {sh_in[7:0], sh_in[7:0]};
                            ser_nxt = SP_DONE;
                            done_nxt = 1'h1;
                        end
                    end
                    SP_READ:
                    begin
                        dout_nxt = osh_r[15];
                        osh_nxt = {osh_r[14:0], 1'h0};
                        ocnt_nxt = ocnt_r + 5'h1;
                        if (ocnt_r == (wide_r ? 5'h0F : 5'h07))
                        begin
                            ocnt_nxt = 5'h0;
                            rd_addr_nxt = rd_addr_r + (wide_r ? (AW+1)'(2) : (AW+1)'(1));
                            rwait_nxt = 2'h2;
                        end
                    end
                    SP_DONE: ; // extra clocks and input ignored
                endcase
            end
            // array read returns well before the next serial edge
            if (rwait_r != 2'h0)
            begin
                rwait_nxt = rwait_r - 2'h1;
                if (rwait_r == 2'h1)
                    osh_nxt = wide_r ? rdata : {(rd_addr_r[0] ? rdata[15:8] : rdata[7:0]), 8'h00};
            end
        end
        oe_nxt = cs_n && (ser_nxt == SP_READ || stat_nxt);
        if (stat_nxt && ser_nxt != SP_READ)
            dout_nxt = ready;
    end

    // with select high and no serial edge the shift, count and command fields hold
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ser_r <= SP_IDLE;
            cnt_r <= 5'h0;
            sh_r <= '0;
            wide_r <= 1'h0;
            cmd_r <= '0;
            done_r <= 1'h0;
            rd_addr_r <= '0;
            rwait_r <= 2'h0;
            osh_r <= 16'h0000;
            ocnt_r <= 5'h0;
            dout_r <= 1'h0;
            stat_r <= 1'h0;
            low_r <= 8'h0;
            oe_r <= 1'h0;
        end
        else
        begin
            ser_r <= ser_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            wide_r <= wide_nxt;
            cmd_r <= cmd_nxt;
            done_r <= done_nxt;
            rd_addr_r <= rd_addr_nxt;
            rwait_r <= rwait_nxt;
            osh_r <= osh_nxt;
            ocnt_r <= ocnt_nxt;
            dout_r <= dout_nxt;
            stat_r <= stat_nxt;
            low_r <= low_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign serial_out = dout_r;
    assign serial_out_oe = oe_r;

    // =====================================================================
    // self-timed programming engine, free of select and serial clock
    sepc_eng_e eng_r, eng_nxt;
    sepc_cmd_s cur_r, cur_nxt;
    logic [AW-1:0] ptr_r, ptr_nxt;
    logic [TIMER_W-1:0] tmr_r, tmr_nxt;
    logic unl_r, unl_nxt, busy_nxt, bulk, erase_op, pop, prog_op;

    assign buf_out_ready = (eng_r == EN_IDLE);
    assign pop = buf_out_valid && buf_out_ready;
    assign prog_op = !(pend_cmd.op inside {CMD_UNLOCK, CMD_LOCK});
    assign bulk = cur_r.op inside {CMD_BULK_ERASE, CMD_BULK_WRITE};
    assign erase_op = cur_r.op inside {CMD_ERASE, CMD_BULK_ERASE};

    always_comb
    begin
        eng_nxt = eng_r;
        cur_nxt = cur_r;
        ptr_nxt = ptr_r;
        tmr_nxt = tmr_r;
        unl_nxt = unl_r;
        busy_nxt = busy_r;
        mreq = '0;
        unique case (eng_r)
            EN_IDLE:
            begin
                if (pop)
                begin
                    if (pend_cmd.op == CMD_UNLOCK)
                        unl_nxt = 1'h1;
                    else if (pend_cmd.op == CMD_LOCK)
                        unl_nxt = 1'h0;
                    else if (unl_r)
                    begin
                        cur_nxt = pend_cmd;
                        ptr_nxt = '0;
                        busy_nxt = 1'h1;
                        eng_nxt = EN_FILL;
                    end
                end
            end
            EN_FILL:
            begin
                // rewriting a word replaces every bit of its enabled lanes, the erase pass is implicit
                mreq.we = 1'h1;
                mreq.wdata = erase_op ? ERASED_WORD : cur_r.data;
                mreq.be = bulk ? 2'h3 : sepc_lanes(cur_r.wide, cur_r.baddr[0]);
                mreq.addr = bulk ? ptr_r : cur_r.baddr[AW:1];
                ptr_nxt = ptr_r + 1'h1;
                if (!bulk || ptr_r == '1)
                begin
                    eng_nxt = EN_TIME;
                    if (!bulk)
                        tmr_nxt = TIMER_W'(WORD_CYCLES - 1);
                    else if (erase_op)
                        tmr_nxt = TIMER_W'(BULK_ERASE_CYCLES - 1);
                    else
                        tmr_nxt = TIMER_W'(BULK_WRITE_CYCLES - 1);
                end
            end
            EN_TIME:
            begin
                tmr_nxt = tmr_r - 1'h1;
                if (tmr_r == '0)
                begin
                    eng_nxt = EN_IDLE;
                    busy_nxt = 1'h0;
                end
            end
            default: eng_nxt = EN_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            eng_r <= EN_IDLE;
            cur_r <= '0;
            ptr_r <= '0;
            tmr_r <= '0;
            unl_r <= UNLOCKED_RST;
            busy_r <= 1'h0;
        end
        else
        begin
            eng_r <= eng_nxt;
            cur_r <= cur_nxt;
            ptr_r <= ptr_nxt;
            tmr_r <= tmr_nxt;
            unl_r <= unl_nxt;
            busy_r <= busy_nxt;
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_erase_all_ones: assert property ((eng_r == EN_FILL && erase_op) |-> mreq.we && mreq.wdata == 16'hFFFF)
        else $error("erase wrote a word that is not all ones");
    a_start_on_pop: assert property ((pop && prog_op && unl_r) |=> busy_r ##1 busy_r)
        else $error("programming did not start after select fell");
    a_status_level: assert property ((oe_r && stat_r && ser_r != SP_READ) |-> dout_r == $past(ready))
        else $error("status output differs from ready state");
    a_word_time: assert property ((eng_r == EN_FILL && !bulk) |=> eng_r == EN_TIME && tmr_r == TIMER_W'(WORD_CYCLES - 1))
        else $error("word cycle length wrong");
    a_bulk_time: assert property ((eng_r == EN_FILL && bulk && ptr_r == '1) |=> tmr_r == (erase_op ? TIMER_W'(BULK_ERASE_CYCLES - 1) : TIMER_W'(BULK_WRITE_CYCLES - 1)))
        else $error("bulk cycle length wrong");
    a_locked_skip: assert property ((pop && !unl_r) |=> !busy_r && eng_r == EN_IDLE)
        else $error("locked device started programming");
    a_select_low_idle: assert property (!cs_lvl |-> ser_r == SP_IDLE && !done_r && !stat_r)
        else $error("decoder active while deselected");
    a_fall_hiz: assert property (cs_fall |=> !serial_out_oe)
        else $error("output still driven after select fell");
    a_self_done: assert property ((eng_r == EN_TIME && tmr_r == '0) |=> !busy_r && eng_r == EN_IDLE)
        else $error("timed cycle did not end on its own");

    c_word_write: cover property (eng_r == EN_FILL && cur_r.op == CMD_WRITE);
    c_bulk_erase: cover property (eng_r == EN_TIME && cur_r.op == CMD_BULK_ERASE);
    c_read_entry: cover property (ser_r == SP_READ && oe_r);
    c_status_ready: cover property (stat_r && busy_r ##[1:1000] stat_r && dout_r);
endmodule

// ---- sepc_pkg.sv ----
/*
 sepc_pkg: constants, command and state types shared by the serial eeprom
 programming controller, its command buffer and its array.
 assumes a 40 MHz system clock.
*/
package sepc_pkg;

    // =====================================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned SELECT_LOW_NS = 250;
    localparam int unsigned SELECT_LOW_CYC = (SELECT_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WORD_CYCLE_NS = 4000000;
    localparam int unsigned BULK_ERASE_NS = 8000000;
    localparam int unsigned BULK_WRITE_NS = 16000000;
    localparam int unsigned WORD_CYC = WORD_CYCLE_NS / CLK_PERIOD_NS;
    localparam int unsigned BULK_ERASE_CYC = BULK_ERASE_NS / CLK_PERIOD_NS;
    localparam int unsigned BULK_WRITE_CYC = BULK_WRITE_NS / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W = 20;

    // =====================================================================
    // array and command format
    localparam int unsigned AW = 7;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic UNLOCKED_RST = 1'h0;
    localparam logic [1:0] OPC_SPECIAL = 2'h0;
    localparam logic [1:0] OPC_WRITE = 2'h1;
    localparam logic [1:0] OPC_READ = 2'h2;
    localparam logic [1:0] OPC_ERASE = 2'h3;
    localparam logic [1:0] SUB_LOCK = 2'h0;
    localparam logic [1:0] SUB_BULK_WRITE = 2'h1;
    localparam logic [1:0] SUB_BULK_ERASE = 2'h2;
    localparam logic [1:0] SUB_UNLOCK = 2'h3;

    typedef enum logic [2:0] {
        CMD_UNLOCK, CMD_LOCK, CMD_ERASE, CMD_WRITE, CMD_BULK_ERASE, CMD_BULK_WRITE
    } sepc_cmd_e;

    typedef struct packed {
        sepc_cmd_e op;
        logic wide;
        logic [AW:0] baddr;
        logic [15:0] data;
    } sepc_cmd_s;

    typedef struct packed {
        logic we;
        logic [1:0] be;
        logic [AW-1:0] addr;
        logic [15:0] wdata;
    } sepc_mem_req_s;

    typedef enum logic [1:0] {SP_IDLE = 2'h0, SP_SHIFT = 2'h1, SP_READ = 2'h3, SP_DONE = 2'h2} sepc_ser_e;
    typedef enum logic [1:0] {EN_IDLE = 2'h0, EN_FILL = 2'h1, EN_TIME = 2'h3} sepc_eng_e;

    // byte lanes touched by one word operation
    function automatic logic [1:0] sepc_lanes(input logic wide, input logic bsel);
        return wide ? 2'h3 : (bsel ? 2'h2 : 2'h1);
    endfunction

endpackage

// ---- sepc_mem.sv ----
/*
 sepc_mem: word array with byte-lane write port and registered read port.
 assumes write and read addresses from the same clock domain.
*/
`timescale 1ns/1ps
module sepc_mem
#(
    parameter int unsigned ADDR_W = 7
)(
    input logic clk,
    input logic we,
    input logic [1:0] be,
    input logic [ADDR_W-1:0] waddr,
    input logic [15:0] wdata,
    input logic [ADDR_W-1:0] raddr,
    output logic [15:0] rdata
);
    logic [15:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge clk)
    begin
        if (we && be[0])
            mem[waddr][7:0] <= wdata[7:0];
        if (we && be[1])
            mem[waddr][15:8] <= wdata[15:8];
        rdata <= mem[raddr];
    end
endmodule

// ---- sepc_buf2.sv ----
/*
 sepc_buf2: two-entry buffer with valid/ready on both sides.
 assumes an asynchronous active-low reset whose release is already synchronised.
*/
`timescale 1ns/1ps
module sepc_buf2
#(
    parameter int unsigned W = 8
)(
    input logic clk,
    input logic rst_n,
    input logic in_valid,
    output logic in_ready,
    input logic [W-1:0] in_data,
    output logic out_valid,
    input logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] e0_r, e0_nxt, e1_r, e1_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = e0_r;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        e0_nxt = e0_r;
        e1_nxt = e1_r;
        cnt_nxt = cnt_r + 2'(push) - 2'(pop);
        if (pop)
            e0_nxt = e1_r;
        if (push && (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)))
            e0_nxt = in_data;
        else if (push)
            e1_nxt = in_data;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            e0_r <= '0;
            e1_r <= '0;
            cnt_r <= 2'h0;
        end
        else
        begin
            e0_r <= e0_nxt;
            e1_r <= e1_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// ---- sepc_host.sv ----
/*
 sepc_host: host model driving select, serial clock and data in.
 assumes the bench clock and a pulled-up data-out wire.
*/
`timescale 1ns/1ps
module sepc_host (
    input wire logic clk,
    input wire logic sdo,
    output logic cs,
    output logic sck,
    output logic sdi
);
    // =====================================================================
    // pin tasks
    initial
    begin
        cs = 1'b0;
        sck = 1'b0;
        sdi = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // two zero clocks lead each frame; they must not count as a start
    task automatic frame(input logic [25:0] b, input int n, input int r, output logic [15:0] q);
        q = 16'h0;
        cs = 1'b1;
        for (int i = -2; i < n + r; i++)
        begin
            sdi = (i < 0) ? 1'b0 : ((i < n) ? b[n-1-i] : ~sdi);
            tick(5);
            sck = 1'b1;
            tick(5);
            if (i >= n)
                q = {q[14:0], sdo};
            sck = 1'b0;
        end
        tick(5);
        cs = 1'b0;
        sdi = ~sdi;
        tick(12);
    endtask
    task automatic poll(output int busy);
        busy = 0;
        cs = 1'b1;
        tick(6);
        while (sdo === 1'b0 && busy < 1000)
        begin
            tick(1);
            busy++;
        end
        cs = 1'b0;
        tick(12);
    endtask
endmodule

// ---- sepc_top_tb_top.sv ----
/*
 sepc_top_tb_top: self-checking bench for the eeprom programming controller.
 assumes sepc_host as the serial host and shortened cycle counts.
*/
`timescale 1ns/1ps
module sepc_top_tb_top;
    typedef struct {logic [25:0] b; int n; int r; logic o; int m;} sepc_row_s;
    localparam int WC = 60;
    // bulk jobs write every word once before their timer starts
    localparam int FILL_CYC = 1 << sepc_pkg::AW;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic wsel;
    logic cs, sck, sdi, so, oe;
    wire sdo = oe ? so : 1'b1;
    int tests_run = 0;
    int n_errors = 0;
    // m: read data for read rows, else busy bound (-1 means no poll)
    sepc_row_s rows [17] = '{
        '{26'h240, 10, 0, 1'b1, 0}, '{26'h260, 10, 0, 1'b1, -1},
        '{26'h220A5A5, 26, 0, 1'b1, 4*WC+FILL_CYC}, '{26'h303, 10, 16, 1'b1, 'hA5A5},
        '{26'h2831234, 26, 0, 1'b1, WC}, '{26'h303, 10, 16, 1'b1, 'h1234},
        '{26'h304, 10, 16, 1'b1, 'hA5A5}, '{26'h383, 10, 0, 1'b1, WC},
        '{26'h303, 10, 16, 1'b1, 'hFFFF}, '{26'h240, 10, 0, 1'b1, 2*WC+FILL_CYC},
        '{26'h304, 10, 16, 1'b1, 'hFFFF}, '{26'h5095A, 19, 0, 1'b0, WC},
        '{26'h304, 10, 16, 1'b1, 'h5AFF}, '{26'h609, 11, 8, 1'b0, 'h005A},
        '{26'h200, 10, 0, 1'b1, -1}, '{26'h2831234, 26, 0, 1'b1, 0},
        '{26'h303, 10, 16, 1'b1, 'hFFFF}};
    always #12.5 clk = ~clk;
    sepc_top #(.WORD_CYCLES(WC), .BULK_ERASE_CYCLES(2*WC), .BULK_WRITE_CYCLES(4*WC)) DUT (
        .clk(clk), .resetn(resetn), .chip_select(cs), .serial_clk(sck), .serial_in(sdi),
        .word_width_select(wsel), .serial_out(so), .serial_out_oe(oe));
    sepc_host u_host (.clk(clk), .sdo(sdo), .cs(cs), .sck(sck), .sdi(sdi));
    // =====================================================================
    // checks and closing
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic rng(input string s, input int lo, input int hi, input int g);
        tests_run++;
        if (g < lo || g > hi)
        begin
            n_errors++;
            $display("[ERR] %s exp %0d..%0d got %0d", s, lo, hi, g);
        end
    endtask
    task automatic complete_run();
        $display("tests_run %0d n_errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #(25 * 60000);
        n_errors++;
        complete_run();
    end
    initial
    begin
        logic [15:0] q;
        int busy;
        wsel = rows[0].o;
        u_host.tick(5);
        chk("oe in reset", 16'h0, {15'h0, oe});
        resetn = 1'b1;
        u_host.tick(5);
        foreach (rows[i])
        begin
            wsel = rows[i].o;
            u_host.frame(rows[i].b, rows[i].n, rows[i].r, q);
            if (rows[i].r > 0)
                chk("read data", rows[i].m[15:0], q);
            else if (rows[i].m >= 0)
            begin
                u_host.poll(busy);
                rng("busy cycles", rows[i].m - 30, rows[i].m, busy);
                chk("oe after select low", 16'h0, {15'h0, oe});
            end
            $display("row %0d done", i);
        end
        u_host.frame(26'h260, 10, 0, q);
        u_host.frame(26'h1C2, 9, 0, q);
        u_host.poll(busy);
        rng("short command busy", 0, 0, busy);
        u_host.frame(26'h384, 10, 0, q);
        u_host.tick(30);
        chk("oe select held low", 16'h0, {15'h0, oe});
        u_host.tick(60);
        u_host.frame(26'h304, 10, 16, q);
        chk("erase without clocks", 16'hFFFF, q);
        $display("select low cycle done");
        resetn = 1'b0;
        u_host.tick(5);
        chk("oe in mid reset", 16'h0, {15'h0, oe});
        resetn = 1'b1;
        u_host.tick(5);
        u_host.frame(26'h2841234, 26, 0, q);
        u_host.poll(busy);
        rng("locked after reset", 0, 0, busy);
        $display("reset lock done");
        complete_run();
    end
endmodule
